/* ocl_defs.svh */
// Constants for the overcurrent limit command logic
`ifndef OCL_DEFS_SVH
`define OCL_DEFS_SVH
`define OCL_CMD_OC_LIMIT   8'h46
`define OCL_CMD_UV_OCLIM   8'h48
`define OCL_NBINS          14
`define OCL_NBOUNDS        13
// Per-phase bin boundaries, bound i at bits [8*i +: 8]
`define OCL_PH_BOUNDS      104'h3A_35_32_2F_2A_27_25_21_1C_19_16_11_0E
// Three-phase stack boundaries
`define OCL_TRI_BOUNDS     104'hAD_9E_94_8B_7E_75_6D_62_55_4B_40_33_2A
// Threshold per bin in 0.25 A units
`define OCL_CUR_QA         112'hF0_DC_C8_C3_AF_A0_96_8C_78_69_5F_4B_3C_32
// Fixed mantissa restored from nonvolatile memory per bin
`define OCL_RESTORE_MANT   112'h3A_35_32_2F_2A_27_25_21_1C_19_16_11_0E_0C
`define OCL_MANT_RST       8'h0C
`define OCL_EXP_HALF_A     5'h01
`define OCL_EXP_ONE_A      5'h00
`define OCL_EXP_QUARTER_A  5'h1E
`define OCL_BCAST_PHASE    8'hFF
`endif

/* ocl_pkg.sv */
// Types for the overcurrent limit command logic
package ocl_pkg;
  typedef struct packed {
    logic        valid;   // Command presented this cycle
    logic        write;   // 1 write, 0 read
    logic [7:0]  cmd;     // Command code
    logic [7:0]  phase;   // Phase field, FFh for broadcast
    logic [15:0] data;    // Write data
  } ocl_req_t;
  typedef struct packed {
    logic        valid;   // Answer present this cycle
    logic        nack;    // Write refused, or read of an unsupported code
    logic [15:0] data;    // Read data
  } ocl_resp_t;
endpackage

/* ocl_limit.sv */
// Overcurrent limit command handling, per-phase binning and stack division
`timescale 1ns/1ps
`default_nettype none
`include "ocl_defs.svh"

// Summary of operation
// - Any written mantissa in writable bits is stored and read back unchanged.
// - Threshold comes from binning the six-bit code, 58 and above gives 60 A.
// - Restore from memory loads one fixed mantissa per supported threshold.
// - Single-device stack: changing bits 15:8 in a direct write is nacked, dropped, flags both faults.
// - Bit 7 change needs stack above 2, bit 6 above 1, else invalid.
// - Broadcast write with phase FFh is a stack level divided among phases.
// - Two phases: level plus 1, shifted right once, then per-phase binning.
// - Four phases: level plus 2, shifted right twice, then per-phase binning.
// - Three phases: stack level binned directly by its own table, 173 up is 60 A.
// - Only the primary answers a broadcast read with phase FFh.
// - Broadcast read returns own threshold times the number of stacked phases.
// - Command 48h is read only and mirrors the undervoltage limit of 44h.
// - That threshold stays relative to the voltage target in output mode units.
// - Bits 15:11 are a read-only exponent, 1 means 0.5 A, 0 means 1 A.
// - Bits 5:0 select the valley current limit threshold applied.
module ocl_limit #(
  parameter int unsigned RESTORE_BIN = 0   // Bin loaded by reset
) (
  input  wire logic           clk_i,         // 200 MHz clock
  input  wire logic           rst_i,         // Synchronous reset, active high
  input  wire logic           ce_i,          // Clock enable, freezes state when low
  input  wire ocl_pkg::ocl_req_t req_i,      // Command request
  output var ocl_pkg::ocl_resp_t resp_o,     // Command answer
  output logic                cml_set_o,     // Pulse: communication fault flag set
  output logic                ivd_set_o,     // Pulse: invalid data flag set
  input  wire logic [2:0]     stack_size_i,  // Stacked phases, 1 to 4
  input  wire logic           primary_i,     // This device is stack primary
  input  wire logic           half_amp_i,    // Exponent selects 0.5 A LSB
  input  wire logic [15:0]    uv_limit_i,    // Undervoltage limit, relative, in output mode units
  input  wire logic           restore_i,     // Restore strobe from memory
  input  wire logic [3:0]     restore_sel_i, // Supported setting to restore
  output logic [7:0]          mantissa_o,    // Stored mantissa
  output logic [3:0]          oc_bin_o,      // Selected threshold bin
  output logic [7:0]          oc_thresh_o    // Threshold in 0.25 A units
);
  import ocl_pkg::*;

  if (RESTORE_BIN >= `OCL_NBINS) begin : g_bad_restore_bin
    $error("RESTORE_BIN out of range");
  end

  // ----------------------------------------------------------------
  // Lookup helpers
  // ----------------------------------------------------------------
  function automatic logic [3:0] bin_of(input logic [7:0] lvl, input logic [103:0] tbl);
    logic [3:0] b;
    b = 4'h0;
    for (int i = 0; i < `OCL_NBOUNDS; i++) begin
      if (lvl >= tbl[8*i +: 8]) begin
        b = 4'(i + 1);
      end
    end
    return b;
  endfunction

  function automatic logic [7:0] pick(input logic [3:0] b, input logic [111:0] tbl);
    logic [7:0] v;
    v = 8'h00;
    for (int i = 0; i < `OCL_NBINS; i++) begin
      if (b == 4'(i)) begin
        v = tbl[8*i +: 8];
      end
    end
    return v;
  endfunction

  localparam logic [3:0] RST_BIN  = 4'(RESTORE_BIN);
  localparam logic [7:0] RST_MANT = pick(RST_BIN, `OCL_RESTORE_MANT);
  localparam logic [7:0] RST_THRESH = pick(RST_BIN, `OCL_CUR_QA);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0]  mant_q, mant_d;
  logic [3:0]  bin_q, bin_d;
  ocl_resp_t   resp_q, resp_d;
  logic        cml_q, cml_d;
  logic        ivd_q, ivd_d;

  logic [4:0]  exp_w;
  logic [15:0] cur_word;
  logic        is_oc;
  logic        is_bcast;
  logic        invalid;
  logic [8:0]  lvl2;
  logic [9:0]  lvl4;
  logic [3:0]  stack_bin;
  logic [10:0] total_qa;
  logic        take;
  logic [7:0]  thresh_q, thresh_d;

  // ----------------------------------------------------------------
  // Command decode and stack division
  // ----------------------------------------------------------------
  always_comb begin
    exp_w    = half_amp_i ? `OCL_EXP_HALF_A : `OCL_EXP_ONE_A;
    cur_word = {exp_w, 3'b000, mant_q};
    is_oc    = req_i.cmd == `OCL_CMD_OC_LIMIT;
    is_bcast = req_i.phase == `OCL_BCAST_PHASE;
    // Restore wins over a command in the same cycle; the command is dropped
    take     = req_i.valid && !restore_i;
    lvl2     = 9'({1'b0, req_i.data[7:0]} + 9'd1);
    lvl4     = 10'({2'b00, req_i.data[7:0]} + 10'd2);
    // Widen before the product so a full stack total does not wrap at eight bits
    total_qa = 11'(thresh_q) * 11'(stack_size_i);
    // Division among two or four phases, then per-phase binning; three phases use their own table
    case (stack_size_i)
      3'd2:    stack_bin = bin_of(lvl2[8:1], `OCL_PH_BOUNDS);
      3'd3:    stack_bin = bin_of(req_i.data[7:0], `OCL_TRI_BOUNDS);
      3'd4:    stack_bin = bin_of(lvl4[9:2], `OCL_PH_BOUNDS);
      default: stack_bin = bin_of({2'b00, req_i.data[5:0]}, `OCL_PH_BOUNDS);
    endcase
    // Exponent and reserved bits only count as a change on a lone device
    invalid = 1'b0;
    if ((stack_size_i == 3'd1) && (req_i.data[15:8] != cur_word[15:8])) begin
      invalid = 1'b1;
    end
    if ((req_i.data[7] != mant_q[7]) && !(stack_size_i > 3'd2)) begin
      invalid = 1'b1;
    end
    if ((req_i.data[6] != mant_q[6]) && !(stack_size_i > 3'd1)) begin
      invalid = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Limit state: stored mantissa, bin and threshold
  // ----------------------------------------------------------------
  always_comb begin
    mant_d = mant_q;
    bin_d  = bin_q;
    if (restore_i) begin
      bin_d  = (restore_sel_i < 4'(`OCL_NBINS)) ? restore_sel_i : 4'(`OCL_NBINS - 1);
      mant_d = pick(bin_d, `OCL_RESTORE_MANT);
    end else if (take && req_i.write && is_oc) begin
      if (is_bcast) begin
        // Store the fixed mantissa of the per-phase bin so reads stay consistent
        bin_d  = stack_bin;
        mant_d = pick(stack_bin, `OCL_RESTORE_MANT);
      end else if (!invalid) begin
        mant_d = req_i.data[7:0];
        bin_d  = bin_of({2'b00, req_i.data[5:0]}, `OCL_PH_BOUNDS);
      end
    end
    // Looked up ahead of the register so the threshold output comes from a flip-flop
    thresh_d = pick(bin_d, `OCL_CUR_QA);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mant_q   <= RST_MANT;
      bin_q    <= RST_BIN;
      thresh_q <= RST_THRESH;
    end else if (ce_i) begin
      mant_q   <= mant_d;
      bin_q    <= bin_d;
      thresh_q <= thresh_d;
    end
  end

  // ----------------------------------------------------------------
  // Command answer and fault flag pulses
  // ----------------------------------------------------------------
  always_comb begin
    resp_d = '0;
    cml_d  = 1'b0;
    ivd_d  = 1'b0;
    if (take && req_i.write) begin
      resp_d.valid = 1'b1;
      if (!is_oc) begin
        // 48h and any other code are not writable here
        resp_d.nack = 1'b1;
        cml_d       = 1'b1;
        ivd_d       = 1'b1;
      end else if (!is_bcast && invalid) begin
        // Broadcast writes are divided, never refused
        resp_d.nack = 1'b1;
        cml_d       = 1'b1;
        ivd_d       = 1'b1;
      end
    end else if (take) begin
      if (req_i.cmd == `OCL_CMD_UV_OCLIM) begin
        resp_d.valid = 1'b1;
        resp_d.data  = uv_limit_i;
      end else if (is_oc && is_bcast) begin
        // Secondaries stay silent on a broadcast read
        resp_d.valid = primary_i;
        resp_d.data  = primary_i ? {`OCL_EXP_QUARTER_A, total_qa} : 16'h0000;
      end else if (is_oc) begin
        resp_d.valid = 1'b1;
        resp_d.data  = cur_word;
      end else begin
        resp_d.valid = 1'b1;
        resp_d.nack  = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      resp_q <= '0;
      cml_q  <= 1'b0;
      ivd_q  <= 1'b0;
    end else if (ce_i) begin
      resp_q <= resp_d;
      cml_q  <= cml_d;
      ivd_q  <= ivd_d;
    end
  end

  assign resp_o      = resp_q;
  assign cml_set_o   = cml_q;
  assign ivd_set_o   = ivd_q;
  assign mantissa_o  = mant_q;
  assign oc_bin_o    = bin_q;
  assign oc_thresh_o = thresh_q;

endmodule // ocl_limit
`default_nettype wire

/* ocl_chk_sva.sv */
// Assertion checker for the overcurrent limit command ports
`timescale 1ns/1ps
`default_nettype none
module ocl_chk (
  input wire logic               clk_i,
  input wire logic               rst_i,
  input wire logic               ce_i,
  input wire ocl_pkg::ocl_req_t  req_i,
  input wire ocl_pkg::ocl_resp_t resp_o,
  input wire logic               cml_set_o,
  input wire logic               ivd_set_o,
  input wire logic [2:0]         stack_size_i,
  input wire logic               primary_i,
  input wire logic [15:0]        uv_limit_i,
  input wire logic               restore_i,
  input wire logic [3:0]         restore_sel_i,
  input wire logic [7:0]         mantissa_o,
  input wire logic [3:0]         oc_bin_o,
  input wire logic [7:0]         oc_thresh_o
);
  import ocl_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic tk, bsr, wr46;
  assign tk = ce_i && req_i.valid && !restore_i;
  // Secondary must stay silent on a whole-stack read
  assign bsr = !req_i.write && req_i.cmd == 8'h46 && req_i.phase == 8'hFF && !primary_i;
  assign wr46 = tk && req_i.write && req_i.cmd == 8'h46;
  sequence s_take; tk && !bsr; endsequence
  sequence s_ans; resp_o.valid; endsequence
  property p_ans; s_take |=> s_ans; endproperty
  a_ans: assert property (p_ans) else $error("answer missing");
  property p_sec; tk && bsr |=> !resp_o.valid; endproperty
  a_sec: assert property (p_sec) else $error("secondary answered");
  property p_flg; cml_set_o || ivd_set_o |-> cml_set_o && ivd_set_o && resp_o.nack; endproperty
  a_flg: assert property (p_flg) else $error("fault flags apart");
  property p_ro; tk && req_i.write && req_i.cmd == 8'h48 |=> resp_o.nack && cml_set_o; endproperty
  a_ro: assert property (p_ro) else $error("mirror written");
  property p_mir; tk && !req_i.write && req_i.cmd == 8'h48 |=> resp_o.data == $past(uv_limit_i); endproperty
  a_mir: assert property (p_mir) else $error("mirror data wrong");
  property p_keep; resp_o.valid && resp_o.nack |-> $stable(mantissa_o); endproperty
  a_keep: assert property (p_keep) else $error("refused write stored");
  property p_top; wr46 && req_i.phase != 8'hFF && req_i.data[5:0] >= 6'd58 |=> resp_o.nack || oc_bin_o == 4'hD;
  endproperty
  a_top: assert property (p_top) else $error("top bin wrong");
  property p_tri; wr46 && req_i.phase == 8'hFF && stack_size_i == 3'h3 && req_i.data[7:0] >= 8'd173
    |=> oc_bin_o == 4'hD && oc_thresh_o == 8'hF0; endproperty
  a_tri: assert property (p_tri) else $error("three phase top wrong");
  property p_rst; restore_i && ce_i && restore_sel_i == 4'h5 |=> mantissa_o == 8'h1C && oc_bin_o == 4'h5;
  endproperty
  a_rst: assert property (p_rst) else $error("restore wrong");
endmodule // ocl_chk
bind ocl_limit ocl_chk u_chk (.*);
`default_nettype wire

/* ocl_host.sv */
// Host model issuing one command per call
`timescale 1ns/1ps
`default_nettype none
module ocl_host (
  input  wire logic             clk_i,  // Clock
  output var ocl_pkg::ocl_req_t req_o   // Command to the block
);
  import ocl_pkg::*;
  initial req_o = '0;
  // Fields inverted after release so a stale value never passes
  task automatic xfer(input logic w, input logic [7:0] c, input logic [7:0] p, input logic [15:0] d);
    @(posedge clk_i);
    req_o <= '{valid: 1'b1, write: w, cmd: c, phase: p, data: d};
    @(posedge clk_i);
    req_o <= '{valid: 1'b0, write: ~w, cmd: ~c, phase: ~p, data: ~d};
    #1;
  endtask
endmodule // ocl_host
`default_nettype wire

/* testbench.sv */
// Self-checking testbench for the overcurrent limit command logic
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin errors++; $display("unexpected %0t got %h want %h", $time, a, b); end end
module testbench;
  import ocl_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, restore_i = 1'b0, primary_i = 1'b1, half_amp_i = 1'b0, ce_i = 1'b1;
  logic [2:0] stack_size_i = 3'h1;
  logic [3:0] restore_sel_i = 4'h0, oc_bin_o;
  logic [15:0] uv_limit_i = 16'hA5C3;
  logic [7:0] mantissa_o, oc_thresh_o;
  logic cml_set_o, ivd_set_o;
  ocl_req_t req_i;
  ocl_resp_t resp_o;
  int errors = 0, n_checks = 0;
  logic [7:0] th_tab [14] = '{8'h32, 8'h3C, 8'h4B, 8'h5F, 8'h69, 8'h78, 8'h8C, 8'h96, 8'hA0, 8'hAF, 8'hC3, 8'hC8,
    8'hDC, 8'hF0};
  logic [7:0] mn_tab [14] = '{8'h0C, 8'h0E, 8'h11, 8'h16, 8'h19, 8'h1C, 8'h21, 8'h25, 8'h27, 8'h2A, 8'h2F, 8'h32,
    8'h35, 8'h3A};
  always #2.5 clk_i = ~clk_i;
  ocl_host host (.clk_i(clk_i), .req_o(req_i));
  ocl_limit uut (.clk_i, .rst_i, .ce_i, .req_i, .resp_o, .cml_set_o, .ivd_set_o, .stack_size_i, .primary_i,
    .half_amp_i, .uv_limit_i, .restore_i, .restore_sel_i, .mantissa_o, .oc_bin_o, .oc_thresh_o);
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic bin_is(input int b);
    `CHK(oc_bin_o, 4'(b))
    `CHK(oc_thresh_o, th_tab[b])
  endtask
  task automatic wr(input logic [7:0] p, input logic [15:0] d, input logic nk);
    host.xfer(1'b1, 8'h46, p, d);
    `CHK({resp_o.valid, resp_o.nack}, {1'b1, nk})
    `CHK({cml_set_o, ivd_set_o}, {nk, nk})
  endtask
  task automatic set_stack(input int n);
    @(posedge clk_i);
    stack_size_i <= 3'(n);
  endtask
  task automatic t_direct;
    int c [5] = '{13, 14, 57, 58, 63};
    int b [5] = '{0, 1, 12, 13, 13};
    for (int i = 0; i < 5; i++) begin
      wr(8'h00, 16'(c[i]), 1'b0);
      bin_is(b[i]);
      host.xfer(1'b0, 8'h46, 8'h00, 16'h0);
      `CHK(resp_o.data, 16'(c[i]))
    end
    $display("direct codes done");
  endtask
  task automatic t_refuse;
    @(posedge clk_i);
    half_amp_i <= 1'b1;
    wr(8'h00, 16'h0811, 1'b0);
    host.xfer(1'b0, 8'h46, 8'h00, 16'h0);
    `CHK(resp_o.data, 16'h0811)
    wr(8'h00, 16'h0012, 1'b1);
    `CHK(mantissa_o, 8'h11)
    wr(8'h00, 16'h0851, 1'b1);
    set_stack(2);
    wr(8'h00, 16'h0851, 1'b0);
    wr(8'h00, 16'h08D1, 1'b1);
    set_stack(3);
    wr(8'h00, 16'h08D1, 1'b0);
    host.xfer(1'b1, 8'h48, 8'h00, 16'h0);
    `CHK(resp_o.nack, 1'b1)
    host.xfer(1'b0, 8'h48, 8'h00, 16'h0);
    `CHK(resp_o.data, 16'hA5C3)
    $display("refusals done");
  endtask
  task automatic t_bcast;
    int s [7] = '{2, 2, 4, 4, 3, 1, 3};
    int l [7] = '{27, 26, 54, 53, 172, 58, 173};
    int b [7] = '{1, 0, 1, 0, 12, 13, 13};
    for (int i = 0; i < 7; i++) begin
      set_stack(s[i]);
      wr(8'hFF, 16'(l[i]), 1'b0);
      bin_is(b[i]);
      `CHK(mantissa_o, mn_tab[b[i]])
    end
    host.xfer(1'b0, 8'h46, 8'hFF, 16'h0);
    `CHK(resp_o.data, 16'hF2D0)
    @(posedge clk_i);
    primary_i <= 1'b0;
    host.xfer(1'b0, 8'h46, 8'hFF, 16'h0);
    `CHK(resp_o.valid, 1'b0)
    $display("broadcast done");
  endtask
  task automatic t_restore;
    @(posedge clk_i);
    restore_i <= 1'b1;
    restore_sel_i <= 4'h5;
    @(posedge clk_i);
    restore_i <= 1'b0;
    #1;
    `CHK(mantissa_o, 8'h1C)
    bin_is(5);
    $display("restore done");
  endtask
  task automatic t_freeze;
    @(posedge clk_i);
    ce_i <= 1'b0;
    host.xfer(1'b1, 8'h46, 8'h00, 16'h003A);
    `CHK(resp_o.valid, 1'b0)
    `CHK(mantissa_o, 8'h1C)
    @(posedge clk_i);
    ce_i <= 1'b1;
    wr(8'h00, 16'h003A, 1'b0);
    `CHK(mantissa_o, 8'h3A)
    $display("clock enable done");
  endtask
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    `CHK(mantissa_o, 8'h0C)
    t_direct();
    t_refuse();
    t_bcast();
    t_restore();
    t_freeze();
    close_out();
  end
  initial begin
    #10000;
    errors++;
    close_out();
  end
endmodule // testbench
`default_nettype wire
